// *** rtl/adc_seq_pkg.sv ***
// constants, register layout and carrier types of the conversion sequencer
package adc_seq_pkg;

    // clock and oscillator
    localparam int CLK_HZ = 10_000_000;
    localparam int OSC_HZ = 512_000;
    // oscillator tick derived as a fraction of the core clock
    localparam int OSC_STEP = OSC_HZ / 1000;
    localparam int OSC_MOD = CLK_HZ / 1000;

    // register pointers
    localparam logic [1:0] PTR_RESULT = 2'h0;
    localparam logic [1:0] PTR_SETUP = 2'h1;
    localparam logic [1:0] PTR_STATUS = 2'h2;

    // conversion_setup layout and reset value
    localparam logic [15:0] SETUP_RESET = 16'h8583;
    localparam int SETUP_START_BIT = 15;
    localparam int SETUP_MODE_BIT = 8;
    localparam int RATE_LSB = 5;
    localparam int RATE_MSB = 7;
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 2;

    // status layout
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_POWER_BIT = 1;
    localparam int STAT_NEW_BIT = 2;

    // result limits
    localparam int RES_W = 24;
    localparam logic [23:0] RES_MAX = 24'h7fffff;
    localparam logic [23:0] RES_MIN = 24'h800000;
    localparam logic [23:0] RES_ZERO = 24'h000000;

    // rates in quarter samples per second: 6.25 .. 1000
    localparam int RATE_QSPS [8] = '{25, 50, 100, 200, 400, 1000, 2000, 4000};
    // conversion period in oscillator ticks: one period of the data rate
    localparam logic [16:0] PERIOD_TICKS [8] = '{
        17'(OSC_HZ * 4 / RATE_QSPS[0]), 17'(OSC_HZ * 4 / RATE_QSPS[1]),
        17'(OSC_HZ * 4 / RATE_QSPS[2]), 17'(OSC_HZ * 4 / RATE_QSPS[3]),
        17'(OSC_HZ * 4 / RATE_QSPS[4]), 17'(OSC_HZ * 4 / RATE_QSPS[5]),
        17'(OSC_HZ * 4 / RATE_QSPS[6]), 17'(OSC_HZ * 4 / RATE_QSPS[7])};
    // shift that scales the decimated sum to 24-bit code: full scale at rates 5 to 7, five eighths of it at rates 0 to 4
    localparam logic [3:0] SCALE_SHIFT [8] = '{4'h6, 4'h7, 4'h8, 4'h9,
        4'ha, 4'hc, 4'hd, 4'he};

    // mux selection codes
    localparam logic [2:0] SEL_D01 = 3'h0;
    localparam logic [2:0] SEL_D23 = 3'h1;
    localparam logic [2:0] SEL_D03 = 3'h2;
    localparam logic [2:0] SEL_D13 = 3'h3;

    typedef enum logic [1:0] {
        ST_POWER_DOWN = 2'b00,
        ST_CONVERT = 2'b01
    } seq_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [23:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [1:0] positive_converter_input;
        logic [1:0] negative_converter_input;
        logic neg_to_ground;
    } mux_route_t;

endpackage : adc_seq_pkg

// *** rtl/osc_tick_gen.sv ***
// fractional divider making the internal oscillator tick from core_clk
`timescale 1ns/1ps
`default_nettype none
module osc_tick_gen #(
    parameter int STEP = 512,
    parameter int MOD = 10000
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    logic [15:0] acc_r;
    logic [16:0] sum;
    logic wrap;

    // phase accumulator wraps once per oscillator period
    assign sum = {1'b0, acc_r} + 17'(STEP);
    assign wrap = sum >= 17'(MOD);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 16'h0000;
            tick <= 1'b0;
        end else begin
            acc_r <= wrap ? 16'(sum - 17'(MOD)) : sum[15:0];
            tick <= wrap;
        end
    end
endmodule : osc_tick_gen
`default_nettype wire

// *** rtl/adc_conversion_sequencer.sv ***
// conversion sequencer: modes, filter, result register and input mux control
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: a start request in single-shot mode runs exactly one conversion.
// RULE_02: a finished single-shot conversion stores its result and powers down.
// RULE_03: in continuous mode the next conversion starts on the finishing edge.
// RULE_04: continuous results come at the programmed data rate.
// RULE_05: the result register reads at any time as the latest finished value.
// RULE_06: bits 2:0 of conversion_setup at pointer 1 pick inputs; reset 8583h.
// RULE_07: four single-ended and two differential pairings are offered.
// RULE_08: first and second inputs can be measured against the fourth.
// RULE_09: single-ended selections switch the negative input to ground.
// RULE_10: single-ended selections never yield negative codes.
// RULE_11: each result is a signed 24-bit code decimated from the bit stream.
// RULE_12: a three-bit rate field picks 6.25 to 1000 samples per second.
// RULE_13: a conversion lasts exactly one data-rate period.
// RULE_14: all timing comes from the internal 512 kHz oscillator tick.
// RULE_15: the result register keeps its value until a conversion completes.
// RULE_16: the host starts single shots by a setup write and waits one period.
module adc_conversion_sequencer #(
    parameter int OSC_STEP = adc_seq_pkg::OSC_STEP,
    parameter int OSC_MOD = adc_seq_pkg::OSC_MOD
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire adc_seq_pkg::bus_req_t bus,
    output logic [23:0] rd_data,
    input wire logic mod_bit,
    output logic converter_power,
    output adc_seq_pkg::mux_route_t route
);
    // reset release synchroniser
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // oscillator tick
    logic osc_tick;

    osc_tick_gen #(
        .STEP(OSC_STEP),
        .MOD(OSC_MOD)
    ) u_osc (
        .clk(core_clk),
        .rst_n(rst_n_r),
        .tick(osc_tick)
    );

    // state
    adc_seq_pkg::seq_state_t state_r;
    adc_seq_pkg::seq_state_t state_nxt;
    logic [15:0] setup_r;
    logic [15:0] setup_nxt;
    logic [16:0] cnt_r;
    logic [16:0] cnt_nxt;
    logic [16:0] period_r;
    logic [3:0] shift_r;
    logic [2:0] sel_r;
    logic signed [17:0] acc_r;
    logic signed [17:0] acc_nxt;
    logic [23:0] result_r;
    logic new_r;
    logic [23:0] rd_data_r;

    // register decode
    wire setup_wr = bus.wr && bus.addr == adc_seq_pkg::PTR_SETUP;
    wire res_rd = bus.rd && bus.addr == adc_seq_pkg::PTR_RESULT;
    wire continuous = !setup_r[adc_seq_pkg::SETUP_MODE_BIT];
    wire busy = state_r == adc_seq_pkg::ST_CONVERT;
    wire start_req = setup_wr && bus.wdata[adc_seq_pkg::SETUP_START_BIT];
    wire wr_single = bus.wdata[adc_seq_pkg::SETUP_MODE_BIT];
    // a start write launches with the fields it carries, not the old ones
    wire [2:0] rate_sel =
        setup_nxt[adc_seq_pkg::RATE_MSB:adc_seq_pkg::RATE_LSB]; // RULE_01
    wire [2:0] in_sel =
        setup_nxt[adc_seq_pkg::SEL_MSB:adc_seq_pkg::SEL_LSB];

    // a conversion ends on the tick that completes its period
    wire conv_done = busy && osc_tick && cnt_r == period_r - 17'h00001;

    // next setup value: start bit is an action, not stored state
    always_comb begin
        setup_nxt = setup_r;
        if (setup_wr) begin
            setup_nxt = bus.wdata[15:0];
            setup_nxt[adc_seq_pkg::SETUP_START_BIT] = 1'b1;
        end
    end

    // launch conditions from power-down
    wire single_go = start_req && wr_single; // RULE_01
    wire cont_go = continuous && !(setup_wr && wr_single); // RULE_03
    wire launch = !busy && (single_go || cont_go);
    wire relaunch = conv_done && continuous
        && !(setup_wr && wr_single); // RULE_03

    // sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            adc_seq_pkg::ST_POWER_DOWN: begin
                if (launch) begin
                    state_nxt = adc_seq_pkg::ST_CONVERT;
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                if (conv_done && !relaunch) begin
                    state_nxt = adc_seq_pkg::ST_POWER_DOWN; // RULE_02
                end
            end
            default: begin
                state_nxt = adc_seq_pkg::ST_POWER_DOWN;
            end
        endcase
    end

    // period counter in oscillator ticks
    always_comb begin
        cnt_nxt = cnt_r;
        if (launch || conv_done) begin
            cnt_nxt = 17'h00000; // RULE_13
        end else if (busy && osc_tick) begin
            cnt_nxt = cnt_r + 17'h00001; // RULE_14
        end
    end

    // decimation: one signed vote per oscillator tick
    wire signed [17:0] vote = mod_bit ? 18'sh00001 : -18'sh00001;
    wire signed [17:0] acc_fin = acc_r + vote; // RULE_11

    always_comb begin
        acc_nxt = acc_r;
        if (launch || conv_done) begin
            acc_nxt = 18'sh00000;
        end else if (busy && osc_tick) begin
            acc_nxt = acc_fin;
        end
    end

    // scale to 24 bits with saturation
    wire [31:0] acc_wide = {{14{acc_fin[17]}}, acc_fin};
    wire [31:0] scaled = acc_wide << shift_r;
    wire fits = &scaled[31:23] || ~|scaled[31:23];
    wire [23:0] sat_code = fits ? scaled[23:0]
        : (scaled[31] ? adc_seq_pkg::RES_MIN : adc_seq_pkg::RES_MAX);
    wire single_ended = sel_r[2];
    wire [23:0] final_code = (single_ended && sat_code[23])
        ? adc_seq_pkg::RES_ZERO : sat_code; // RULE_10

    // settings are latched at each conversion start
    wire take_settings = launch || relaunch; // RULE_04

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= adc_seq_pkg::ST_POWER_DOWN;
            setup_r <= adc_seq_pkg::SETUP_RESET; // RULE_06
            cnt_r <= 17'h00000;
            acc_r <= 18'sh00000;
        end else begin
            state_r <= state_nxt;
            setup_r <= setup_nxt;
            cnt_r <= cnt_nxt;
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            period_r <= adc_seq_pkg::PERIOD_TICKS[0];
            shift_r <= adc_seq_pkg::SCALE_SHIFT[0];
            sel_r <= 3'h0;
        end else if (take_settings) begin
            period_r <= adc_seq_pkg::PERIOD_TICKS[rate_sel]; // RULE_12
            shift_r <= adc_seq_pkg::SCALE_SHIFT[rate_sel];
            sel_r <= in_sel; // RULE_06
        end
    end

    // result register changes only when a conversion completes
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            result_r <= adc_seq_pkg::RES_ZERO;
        end else if (conv_done) begin
            result_r <= final_code; // RULE_15
        end
    end

    // fresh-result flag: set by completion, cleared by reading the result
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            new_r <= 1'b0;
        end else if (conv_done) begin
            new_r <= 1'b1;
        end else if (res_rd) begin
            new_r <= 1'b0;
        end
    end

    // read data mux
    wire [23:0] status_word = {21'h00000, new_r, busy, busy};
    wire [15:0] setup_view = {!busy, setup_r[14:0]};
    wire [23:0] rd_word =
        bus.addr == adc_seq_pkg::PTR_RESULT ? result_r : // RULE_05
        bus.addr == adc_seq_pkg::PTR_SETUP ? {8'h00, setup_view} :
        bus.addr == adc_seq_pkg::PTR_STATUS ? status_word : 24'h000000;

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_data_r <= 24'h000000;
        end else begin
            rd_data_r <= bus.rd ? rd_word : 24'h000000;
        end
    end

    assign rd_data = rd_data_r;

    // input multiplexer routing from the latched selection
    always_comb begin
        route.neg_to_ground = single_ended; // RULE_09
        route.positive_converter_input = sel_r[1:0];
        route.negative_converter_input = 2'h3;
        unique case (sel_r)
            adc_seq_pkg::SEL_D01: begin
                route.positive_converter_input = 2'h0; // RULE_07
                route.negative_converter_input = 2'h1;
            end
            adc_seq_pkg::SEL_D23: begin
                route.positive_converter_input = 2'h2; // RULE_07
                route.negative_converter_input = 2'h3;
            end
            adc_seq_pkg::SEL_D03: begin
                route.positive_converter_input = 2'h0; // RULE_08
            end
            adc_seq_pkg::SEL_D13: begin
                route.positive_converter_input = 2'h1; // RULE_08
            end
            3'h4, 3'h5, 3'h6, 3'h7: begin
                route.negative_converter_input = 2'h0; // RULE_07
            end
        endcase
    end

    // analog section powered only while converting
    assign converter_power = busy; // RULE_02

    // tick spacing helper for the assertions
    logic [16:0] tick_seen_r;

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tick_seen_r <= 17'h00000;
        end else if (take_settings) begin
            tick_seen_r <= 17'h00000;
        end else if (busy && osc_tick) begin
            tick_seen_r <= tick_seen_r + 17'h00001;
        end
    end

    property p_single_start;
        @(posedge core_clk) disable iff (!rst_n_r)
        (!busy && setup_wr && bus.wdata[15] && bus.wdata[8])
            |=> busy && cnt_r == 17'h00000;
    endproperty
    a_single_start: assert property (p_single_start) // RULE_01
        else $error("single-shot request did not start a conversion");

    property p_single_stop;
        @(posedge core_clk) disable iff (!rst_n_r)
        (conv_done && setup_r[8] && !setup_wr) |=> !busy && !converter_power;
    endproperty
    a_single_stop: assert property (p_single_stop) // RULE_02
        else $error("single-shot conversion did not power down");

    property p_cont_restart;
        @(posedge core_clk) disable iff (!rst_n_r)
        (conv_done && !setup_r[8] && !setup_wr)
            |=> busy && cnt_r == 17'h00000 && acc_r == 18'sh00000;
    endproperty
    a_cont_restart: assert property (p_cont_restart) // RULE_03
        else $error("continuous mode did not restart at once");

    property p_period_len;
        @(posedge core_clk) disable iff (!rst_n_r)
        conv_done |-> tick_seen_r == period_r - 17'h00001;
    endproperty
    a_period_len: assert property (p_period_len) // RULE_13
        else $error("conversion length differs from one rate period");

    property p_result_read;
        @(posedge core_clk) disable iff (!rst_n_r)
        res_rd |=> rd_data == $past(result_r);
    endproperty
    a_result_read: assert property (p_result_read) // RULE_05
        else $error("result read returned a stale value");

    property p_result_hold;
        @(posedge core_clk) disable iff (!rst_n_r)
        !conv_done |=> $stable(result_r);
    endproperty
    a_result_hold: assert property (p_result_hold) // RULE_15
        else $error("result changed without a finished conversion");

    property p_se_positive;
        @(posedge core_clk) disable iff (!rst_n_r)
        (conv_done && sel_r[2]) |=> !result_r[23];
    endproperty
    a_se_positive: assert property (p_se_positive) // RULE_10
        else $error("single-ended result is negative");

    property p_se_ground;
        @(posedge core_clk) disable iff (!rst_n_r)
        busy && sel_r[2] |-> route.neg_to_ground
            && route.positive_converter_input == sel_r[1:0];
    endproperty
    a_se_ground: assert property (p_se_ground) // RULE_09
        else $error("single-ended route not grounded on negative input");

    property p_rate_latch;
        @(posedge core_clk) disable iff (!rst_n_r)
        take_settings
            |=> period_r == $past(adc_seq_pkg::PERIOD_TICKS[rate_sel]);
    endproperty
    a_rate_latch: assert property (p_rate_latch) // RULE_04
        else $error("conversion period does not follow the rate field");

    property p_cont_idle_start;
        @(posedge core_clk) disable iff (!rst_n_r)
        (!busy && continuous && !setup_wr) |=> busy && cnt_r == 17'h00000;
    endproperty
    a_cont_idle_start: assert property (p_cont_idle_start) // RULE_03
        else $error("continuous mode left the converter idle");

    property p_new_flag;
        @(posedge core_clk) disable iff (!rst_n_r)
        conv_done |=> new_r && result_r == $past(final_code);
    endproperty
    a_new_flag: assert property (p_new_flag) // RULE_02
        else $error("finished conversion not stored or not flagged");

endmodule : adc_conversion_sequencer
`default_nettype wire

// *** bench/analog_source_model.sv ***
// modulator stand-in: vote stream from four fixed analog input levels
`timescale 1ns/1ps
`default_nettype none
module analog_source_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire adc_seq_pkg::mux_route_t route,
    output logic mod_bit
);
    // input levels: first +1, second -1, third balanced, fourth +1
    localparam int LEVEL [4] = '{1, -1, 0, 1};
    int diff;
    logic flip_r;

    // difference seen across the converter inputs
    always_comb begin
        diff = LEVEL[route.positive_converter_input];
        if (!route.neg_to_ground) begin
            diff = diff - LEVEL[route.negative_converter_input];
        end
    end

    // balanced input alternates votes so the sum stays near zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flip_r <= 1'b0;
        end else begin
            flip_r <= ~flip_r;
        end
    end

    assign mod_bit = (diff > 0) ? 1'b1 : ((diff < 0) ? 1'b0 : flip_r);
endmodule : analog_source_model
`default_nettype wire

// *** bench/adc_conversion_sequencer_tb.sv ***
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    adc_seq_pkg::bus_req_t bus = '0;
    logic [23:0] rd_data;
    logic mod_bit;
    logic converter_power;
    adc_seq_pkg::mux_route_t route;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    // expected route and code for each input selection
    logic [1:0] exp_pos [8] = '{2'h0, 2'h2, 2'h0, 2'h1,
        2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0] exp_neg [8] = '{2'h1, 2'h3, 2'h3, 2'h3,
        2'h0, 2'h0, 2'h0, 2'h0};
    logic [23:0] exp_code [8] = '{24'h7fffff, 24'h800000, 24'h000000,
        24'h800000, 24'h7fffff, 24'h000000, 24'h000000, 24'h7fffff};

    always #50 core_clk = ~core_clk;

    // tick every core clock: 1000 SPS lasts 512 cycles
    adc_conversion_sequencer #(.OSC_STEP(1), .OSC_MOD(1)) dut_u (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .bus(bus),
        .rd_data(rd_data),
        .mod_bit(mod_bit),
        .converter_power(converter_power),
        .route(route)
    );

    analog_source_model src_u (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .route(route),
        .mod_bit(mod_bit)
    );

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test;
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // code compare allowing two misplaced votes at the frame edges
    task automatic near(input logic [23:0] got, input logic [23:0] exp);
        logic signed [24:0] dd;
        dd = $signed({got[23], got}) - $signed({exp[23], exp});
        checks_done++;
        if ((^got === 1'bx) || dd > 25'sh10000 || dd < -25'sh10000) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : near

    function automatic logic [23:0] cfg(input logic st, input logic md,
        input logic [2:0] rt, input logic [2:0] sl);
        return {8'h00, st, 6'h00, md, rt, 2'h0, sl};
    endfunction : cfg

    task automatic wr(input logic [1:0] a, input logic [23:0] d);
        @(posedge core_clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [23:0] d);
        @(posedge core_clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(negedge core_clk);
        d = rd_data;
    endtask : rd

    task automatic test_reset;
        logic [23:0] d;
        chk({23'h0, converter_power}, 24'h0);
        rd(adc_seq_pkg::PTR_SETUP, d);
        chk(d, {8'h00, adc_seq_pkg::SETUP_RESET});
        rd(2'h3, d);
        chk(d, 24'h0);
        wr(2'h3, 24'hffffff);
        wr(adc_seq_pkg::PTR_RESULT, 24'h123456);
        rd(adc_seq_pkg::PTR_RESULT, d);
        chk(d, 24'h0);
        rd(adc_seq_pkg::PTR_SETUP, d);
        chk(d, {8'h00, adc_seq_pkg::SETUP_RESET});
    endtask : test_reset

    task automatic single_shot(input logic [2:0] sel);
        logic [23:0] prev;
        logic [23:0] d;
        adc_seq_pkg::mux_route_t r;
        time t0;
        int n;
        rd(adc_seq_pkg::PTR_RESULT, prev);
        wr(adc_seq_pkg::PTR_SETUP, cfg(1'b1, 1'b1, 3'h7, sel));
        @(negedge core_clk);
        t0 = $time;
        chk({23'h0, converter_power}, 24'h1);
        r = route;
        chk(24'(r.positive_converter_input), 24'(exp_pos[sel]));
        chk(24'(r.neg_to_ground), 24'(sel[2]));
        if (!sel[2]) begin
            chk(24'(r.negative_converter_input), 24'(exp_neg[sel]));
        end
        // second start while busy must not queue another conversion
        wr(adc_seq_pkg::PTR_SETUP, cfg(1'b1, 1'b1, 3'h7, sel));
        rd(adc_seq_pkg::PTR_RESULT, d);
        chk(d, prev);
        rd(adc_seq_pkg::PTR_SETUP, d);
        chk({23'h0, d[15]}, 24'h0);
        n = 0;
        while (converter_power === 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        n = int'(($time - t0) / 100);
        chk({23'h0, n >= 512 && n <= 514}, 24'h1);
        repeat (20) @(negedge core_clk);
        chk({23'h0, converter_power}, 24'h0);
        rd(adc_seq_pkg::PTR_STATUS, d);
        chk({23'h0, d[2]}, 24'h1);
        rd(adc_seq_pkg::PTR_RESULT, d);
        near(d, exp_code[sel]);
        rd(adc_seq_pkg::PTR_RESULT, prev);
        chk(prev, d);
    endtask : single_shot

    // poll until a fresh result is flagged, then clear the flag
    task automatic wait_new(output time t);
        logic [23:0] d;
        int n;
        n = 0;
        do begin
            rd(adc_seq_pkg::PTR_STATUS, d);
            n++;
        end while (d[2] !== 1'b1 && n < 1000);
        t = $time;
        rd(adc_seq_pkg::PTR_RESULT, d);
    endtask : wait_new

    task automatic test_cont;
        time t1;
        time t2;
        int n;
        wr(adc_seq_pkg::PTR_SETUP, cfg(1'b0, 1'b0, 3'h7, 3'h4));
        wait_new(t1);
        wait_new(t2);
        n = int'((t2 - t1) / 100);
        chk({23'h0, n >= 508 && n <= 516}, 24'h1);
        chk({23'h0, converter_power}, 24'h1);
        wr(adc_seq_pkg::PTR_SETUP, cfg(1'b0, 1'b0, 3'h6, 3'h4));
        wait_new(t1);
        wait_new(t2);
        n = int'((t2 - t1) / 100);
        chk({23'h0, n >= 1020 && n <= 1028}, 24'h1);
        // back to single mode: current conversion ends, then power down
        wr(adc_seq_pkg::PTR_SETUP, cfg(1'b0, 1'b1, 3'h6, 3'h4));
        n = 0;
        while (converter_power === 1'b1 && n < 1200) begin
            @(negedge core_clk);
            n++;
        end
        repeat (50) @(negedge core_clk);
        chk({23'h0, converter_power}, 24'h0);
    endtask : test_cont

    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        test_reset;
        for (int s = 0; s < 8; s++) begin
            single_shot(3'(s));
        end
        test_cont;
        stop_test;
    end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
